// file: logic/alu_flags.sv
// compare / decrement arithmetic with flag generation
// purely combinational, operand width chosen per call
`timescale 1ns/100ps
`default_nettype none
module alu_flags (
  input wire logic [15:0] a,      // left operand
  input wire logic [15:0] b,      // right operand (subtrahend)
  input wire logic word,          // 1 = 16-bit, 0 = 8-bit
  output logic [15:0] diff,       // a - b at chosen width
  output logic n,                 // sign of result
  output logic z,                 // result zero
  output logic v,                 // signed overflow
  output logic c                  // borrow
);
  logic [16:0] d16;
  logic [8:0] d8;
  always_comb begin
    d16 = {1'b0, a} - {1'b0, b};
    d8 = {1'b0, a[7:0]} - {1'b0, b[7:0]};
    if (word) begin
      diff = d16[15:0];
      n = d16[15];
      z = (d16[15:0] == 16'h0000);
      v = (a[15] ^ b[15]) & (a[15] ^ d16[15]);
      c = d16[16];
    end else begin
      diff = {8'h00, d8[7:0]};
      n = d8[7];
      z = (d8[7:0] == 8'h00);
      v = (a[7] ^ b[7]) & (a[7] ^ d8[7]);
      c = d8[8];
    end
  end
endmodule
`default_nettype wire

// file: logic/branch2_pkg.sv
// package for the branch group two execution unit
// assumes a decoder hands over an opcode class plus operands in one packet
package branch2_pkg;

  typedef enum logic [3:0] {
    OP_CMP_BYTE_A   = 4'h0,
    OP_CMP_WORD_A   = 4'h1,
    OP_CMP_BYTE_REG = 4'h2,
    OP_CMP_WORD_REG = 4'h3,
    OP_CMP_BYTE_MEM = 4'h4,
    OP_CMP_WORD_MEM = 4'h5,
    OP_DEC_BYTE_REG = 4'h6,
    OP_DEC_WORD_REG = 4'h7,
    OP_DEC_BYTE_MEM = 4'h8,
    OP_DEC_WORD_MEM = 4'h9,
    OP_TRAP_FAR     = 4'ha,
    OP_TRAP_EXIT    = 4'hb,
    OP_RET_WORD     = 4'hc,
    OP_RET_LONG     = 4'hd,
    OP_FRAME_SETUP  = 4'he,
    OP_FRAME_DROP   = 4'hf
  } op_t;

  // flag byte: bit positions inside the condition code word
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_T = 4;
  localparam int FLAG_S = 5;
  localparam int FLAG_I = 6;

  // base cycle counts (taken / not taken)
  localparam logic [4:0] CYC_CMP_A_TK = 5'h05;
  localparam logic [4:0] CYC_CMP_A_NT = 5'h04;
  localparam logic [4:0] CYC_CMPB_R_TK = 5'h0d;
  localparam logic [4:0] CYC_CMPB_R_NT = 5'h0c;
  localparam logic [4:0] CYC_CMPW_R_TK = 5'h08;
  localparam logic [4:0] CYC_CMPW_R_NT = 5'h07;
  localparam logic [4:0] CYC_CMP_M_TK = 5'h07;
  localparam logic [4:0] CYC_CMP_M_NT = 5'h06;
  localparam logic [4:0] CYC_DEC_R_TK = 5'h07;
  localparam logic [4:0] CYC_DEC_R_NT = 5'h06;
  localparam logic [4:0] CYC_DEC_M_TK = 5'h08;
  localparam logic [4:0] CYC_DEC_M_NT = 5'h07;
  localparam logic [4:0] CYC_TRAP = 5'h11;
  localparam logic [4:0] CYC_TRAP_EXIT = 5'h11;
  localparam logic [4:0] CYC_RET_WORD = 5'h04;
  localparam logic [4:0] CYC_RET_LONG = 5'h06;
  localparam logic [4:0] CYC_FRAME = 5'h05;
  localparam logic [4:0] CYC_FRAME_DROP = 5'h05;

  // trap bus traffic: entry = bytes + words, exit = words
  localparam logic [2:0] TRAP_BYTE_ACC = 3'h3;
  localparam logic [2:0] TRAP_WORD_ACC = 3'h2;
  localparam logic [2:0] TRAP_EXIT_WORD_ACC = 3'h6;

  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [15:0] RESET_SP = 16'h0000;

  typedef struct packed {
    op_t op;
    logic [15:0] imm;     // imm8 in low byte for byte forms
    logic [7:0] disp;     // signed displacement
    logic [15:0] opnd;    // register operand value
    logic [15:0] ea;      // memory effective address
    logic [4:0] ea_cost;  // addressing mode cost (a)
    logic [23:0] target;  // trap vector target
  } instr_t;

  typedef struct packed {
    logic req;
    logic we;
    logic word;
    logic lock;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

endpackage

// file: logic/cpu_branch_group_two_exec.sv
// execution unit for compare/decrement branches, traps, returns, frames
// assumes the decoder delivers one instr_t at a time, bus answers in order
// Overview of operation
// - compare accumulator byte/word with immediate, branch if unequal, set NZVC
// - accumulator compare branches take 5 cycles taken, 4 not taken
// - byte register compare takes 13 cycles taken, 12 not taken
// - memory compare takes 7+(a) taken, 6+(a) not taken
// - word register compare takes 8 cycles taken, 7 not taken
// - byte decrement writes back, branches if nonzero, NZV set, C kept
// - word decrement behaves as byte form at 16 bits
// - register decrement branch takes 7 taken, 6 not taken
// - memory decrement branch takes 8+(a) taken, 7+(a) not taken
// - memory decrement is a locked read then write of operand width
// - trap entry uses 3 byte plus 2 word accesses; exit 6 words
// - trap exit restores all flags including I and S, 17 cycles
// - word return pops 16-bit PC in 4 cycles, flags untouched
// - long return pops PC and bank in 6 cycles, flags untouched
// - frame setup pushes frame pointer, reloads it, reserves imm8 bytes
// - frame teardown restores frame pointer and releases locals
`timescale 1ns/100ps
`default_nettype none
module cpu_branch_group_two_exec
  import branch2_pkg::*;
(
  input wire logic sys_clk,                 // 20 MHz core clock
  input wire logic rst,                     // sync reset, active high
  input wire logic instr_valid,             // instruction offered
  input wire branch2_pkg::instr_t instr,    // decoded instruction
  input wire logic [15:0] next_pc,          // address after instruction
  input wire logic [15:0] acc,              // accumulator low word
  output logic instr_ready,                 // unit idle, takes instr
  output branch2_pkg::bus_req_t bus,        // memory request
  input wire logic bus_ack,                 // request done this cycle
  input wire logic [15:0] bus_rdata,        // read data on ack
  output logic done,                        // last cycle of instruction
  output logic [15:0] pc,                   // program counter
  output logic [7:0] pc_bank,               // program bank
  output logic [7:0] flags,                 // condition code byte
  output logic [15:0] sp,                   // stack pointer
  output logic [15:0] fp,                   // frame pointer
  output logic reg_we,                      // register write-back strobe
  output logic [15:0] reg_wdata             // register write-back value
);
  import branch2_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_READ = 5'b00010,
    S_WRITE = 5'b00100,
    S_STACK = 5'b01000,
    S_WAIT = 5'b10000
  } state_t;

  function automatic logic is_word(input op_t o);
    return o inside {OP_CMP_WORD_A, OP_CMP_WORD_REG, OP_CMP_WORD_MEM,
                     OP_DEC_WORD_REG, OP_DEC_WORD_MEM};
  endfunction

  function automatic logic [15:0] rel_target(input logic [15:0] base,
                                             input logic [7:0] d);
    return base + {{8{d[7]}}, d};
  endfunction

  state_t state, next_state;
  instr_t cur, next_cur;
  logic [15:0] pc_n;
  logic [7:0] bank_n, flags_n;
  logic [15:0] sp_n, fp_n;
  logic [2:0] acc_cnt, next_acc_cnt;
  logic [15:0] hold, next_hold;
  logic [15:0] npc, next_npc;
  logic taken, next_taken;
  logic [5:0] len;
  logic tload, tbusy, tlast;

  logic [15:0] alu_a;
  logic [15:0] diff;
  logic an, az, av, ac;
  logic mem_op, dec_op;

  alu_flags u_alu (
    .a(alu_a),
    .b(cur.op inside {OP_DEC_BYTE_REG, OP_DEC_WORD_REG,
                      OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM} ? 16'h0001 : cur.imm),
    .word(is_word(cur.op)),
    .diff(diff),
    .n(an),
    .z(az),
    .v(av),
    .c(ac)
  );

  cycle_timer #(.WIDTH(6)) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tload),
    .len(len),
    .busy(tbusy),
    .last(tlast)
  );

  assign mem_op = cur.op inside {OP_CMP_BYTE_MEM, OP_CMP_WORD_MEM,
                                 OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM};
  assign dec_op = cur.op inside {OP_DEC_BYTE_REG, OP_DEC_WORD_REG,
                                 OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM};

  // operand source: accumulator, register, or word fetched from memory
  always_comb begin
    case (cur.op)
      OP_CMP_BYTE_A, OP_CMP_WORD_A: alu_a = acc;
      OP_CMP_BYTE_MEM, OP_CMP_WORD_MEM,
      OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM: alu_a = hold;
      default: alu_a = cur.opnd;
    endcase
  end

  // timer length after any bus accesses; taken branches cost one more cycle for the refetch
  function automatic logic [5:0] cycles(input op_t o, input logic tk,
                                        input logic [4:0] a);
    logic [4:0] b;
    b = 5'h01;
    case (o)
      OP_CMP_BYTE_A, OP_CMP_WORD_A: b = tk ? CYC_CMP_A_TK : CYC_CMP_A_NT;
      OP_CMP_BYTE_REG: b = tk ? CYC_CMPB_R_TK : CYC_CMPB_R_NT;
      OP_CMP_WORD_REG: b = tk ? CYC_CMPW_R_TK : CYC_CMPW_R_NT;
      OP_CMP_BYTE_MEM, OP_CMP_WORD_MEM:
        return {1'b0, tk ? CYC_CMP_M_TK : CYC_CMP_M_NT} + {1'b0, a};
      OP_DEC_BYTE_REG, OP_DEC_WORD_REG:
        b = tk ? CYC_DEC_R_TK : CYC_DEC_R_NT;
      OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM:
        return {1'b0, tk ? CYC_DEC_M_TK : CYC_DEC_M_NT} + {1'b0, a};
      OP_TRAP_FAR: b = CYC_TRAP;
      OP_TRAP_EXIT: b = CYC_TRAP_EXIT;
      OP_RET_WORD: b = CYC_RET_WORD;
      OP_RET_LONG: b = CYC_RET_LONG;
      OP_FRAME_SETUP: b = CYC_FRAME;
      OP_FRAME_DROP: b = CYC_FRAME_DROP;
      default: b = 5'h01;
    endcase
    return {1'b0, b};
  endfunction

  // number of stack accesses each op needs; zero for memory operand forms
  function automatic logic [2:0] accesses(input op_t o);
    case (o)
      OP_TRAP_FAR: return TRAP_BYTE_ACC + TRAP_WORD_ACC;
      OP_TRAP_EXIT: return TRAP_EXIT_WORD_ACC;
      OP_RET_WORD: return 3'h1;
      OP_RET_LONG: return 3'h2;
      OP_FRAME_SETUP: return 3'h1;
      OP_FRAME_DROP: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_npc = npc;
    next_hold = hold;
    next_taken = taken;
    next_acc_cnt = acc_cnt;
    pc_n = pc;
    bank_n = pc_bank;
    flags_n = flags;
    sp_n = sp;
    fp_n = fp;
    tload = 1'b0;
    len = 6'h01;
    bus = '0;
    reg_we = 1'b0;
    reg_wdata = diff;
    done = 1'b0;
    case (state)
      S_IDLE: begin
        if (instr_valid) begin
          next_cur = instr;
          next_npc = next_pc;
          next_acc_cnt = accesses(instr.op);
          if (instr.op inside {OP_CMP_BYTE_MEM, OP_CMP_WORD_MEM,
                               OP_DEC_BYTE_MEM, OP_DEC_WORD_MEM}) begin
            next_state = S_READ;
          end else if (accesses(instr.op) != 3'h0) begin
            next_state = S_STACK;
          end else begin
            next_state = S_WAIT;  // register and accumulator forms
          end
        end
      end
      S_READ: begin
        bus.req = 1'b1;
        bus.word = is_word(cur.op);
        bus.addr = cur.ea;
        bus.lock = dec_op;
        if (bus_ack) begin
          next_hold = bus_rdata;
          next_state = dec_op ? S_WRITE : S_WAIT;
        end
      end
      S_WRITE: begin
        // second half of the locked read-modify-write
        bus.req = 1'b1;
        bus.we = 1'b1;
        bus.lock = 1'b1;
        bus.word = is_word(cur.op);
        bus.addr = cur.ea;
        bus.wdata = diff;
        if (bus_ack) begin
          next_state = S_WAIT;
        end
      end
      S_STACK: begin
        bus.req = 1'b1;
        bus.word = 1'b1;
        case (cur.op)
          OP_TRAP_FAR: begin
            // flags, bank as bytes, then pc and word frame
            bus.we = 1'b1;
            bus.word = (acc_cnt <= TRAP_WORD_ACC);
            bus.addr = sp - 16'h0002;
            bus.wdata = (acc_cnt == 3'h5) ? {8'h00, flags} :
                        (acc_cnt == 3'h4) ? {8'h00, pc_bank} : npc;
            if (bus_ack) sp_n = sp - 16'h0002;
          end
          OP_FRAME_SETUP: begin
            bus.we = 1'b1;
            bus.addr = sp - 16'h0002;
            bus.wdata = fp;
            if (bus_ack) begin
              fp_n = sp - 16'h0002;
              sp_n = sp - 16'h0002 - {8'h00, cur.imm[7:0]};
            end
          end
          OP_FRAME_DROP: begin
            bus.addr = fp;
            if (bus_ack) begin
              fp_n = bus_rdata;
              sp_n = fp + 16'h0002;
            end
          end
          default: begin
            // pops: trap exit, word and long return
            bus.addr = sp;
            if (bus_ack) begin
              sp_n = sp + 16'h0002;
              if (acc_cnt == 3'h1) begin
                if (cur.op == OP_RET_LONG) bank_n = bus_rdata[7:0];
                else if (cur.op == OP_TRAP_EXIT)
                  flags_n = bus_rdata[7:0];
                else next_npc = bus_rdata;
              end else if (acc_cnt == 3'h2 || cur.op == OP_TRAP_EXIT) begin
                if (acc_cnt == 3'h2 && cur.op == OP_TRAP_EXIT)
                  bank_n = bus_rdata[7:0];
                else if (acc_cnt == 3'h3 || cur.op == OP_RET_LONG)
                  next_npc = bus_rdata;
              end
            end
          end
        endcase
        if (bus_ack) begin
          next_acc_cnt = acc_cnt - 3'h1;
          if (acc_cnt == 3'h1) next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!tbusy) begin
          next_taken = dec_op ? !az : !az;
          tload = 1'b1;
          len = cycles(cur.op, !az, cur.ea_cost);
          if (cur.op inside {OP_RET_WORD, OP_RET_LONG, OP_TRAP_EXIT,
                             OP_TRAP_FAR, OP_FRAME_SETUP, OP_FRAME_DROP})
            len = cycles(cur.op, 1'b0, 5'h00);
          if (dec_op) begin
            flags_n[FLAG_N] = an;
            flags_n[FLAG_Z] = az;
            flags_n[FLAG_V] = av;  // carry left alone
            reg_we = !mem_op;
          end else if (cur.op < OP_DEC_BYTE_REG) begin
            flags_n[FLAG_N] = an;
            flags_n[FLAG_Z] = az;
            flags_n[FLAG_V] = av;
            flags_n[FLAG_C] = ac;
          end
        end else if (tlast) begin
          done = 1'b1;
          next_state = S_IDLE;
          if (cur.op <= OP_DEC_WORD_MEM)
            pc_n = taken ? rel_target(npc, cur.disp) : npc;
          else if (cur.op == OP_TRAP_FAR) begin
            pc_n = cur.target[15:0];
            bank_n = cur.target[23:16];
            flags_n[FLAG_S] = 1'b1;
            flags_n[FLAG_I] = 1'b0;  // entry masks further interrupts
          end else
            pc_n = npc;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  assign instr_ready = (state == S_IDLE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
      cur <= '0;
      npc <= RESET_PC;
      hold <= 16'h0000;
      taken <= 1'b0;
      acc_cnt <= 3'h0;
      pc <= RESET_PC;
      pc_bank <= 8'h00;
      flags <= RESET_FLAGS;
      sp <= RESET_SP;
      fp <= RESET_SP;
    end else begin
      state <= next_state;
      cur <= next_cur;
      npc <= next_npc;
      hold <= next_hold;
      taken <= next_taken;
      acc_cnt <= next_acc_cnt;
      pc <= pc_n;
      pc_bank <= bank_n;
      flags <= flags_n;
      sp <= sp_n;
      fp <= fp_n;
    end
  end
endmodule
`default_nettype wire

// file: logic/cycle_timer.sv
// counts out the cycles an instruction occupies
// assumes load pulses only while idle
`timescale 1ns/100ps
`default_nettype none
module cycle_timer #(
  parameter int WIDTH = 6
) (
  input wire logic sys_clk,          // core clock
  input wire logic rst,              // sync reset
  input wire logic load,             // start a count
  input wire logic [WIDTH-1:0] len,  // cycles to occupy
  output logic busy,                 // count running
  output logic last                  // final cycle of count
);
  initial begin
    if (WIDTH < 3) $error("cycle_timer width too small");
  end
  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = len;
    end else if (cnt != '0) begin
      next_cnt = cnt - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign busy = (cnt != '0);
  assign last = (cnt == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// file: verification/branch2_exec_sva.sv
// port assertions for the branch group two execution unit
// assumes sync active-high reset and one instruction in flight at a time
`timescale 1ns/100ps
`default_nettype none
module branch2_exec_chk
  import branch2_pkg::*;
(
  input wire logic sys_clk,                 // core clock
  input wire logic rst,                     // sync reset
  input wire logic instr_valid,             // instruction offered
  input wire branch2_pkg::instr_t instr,    // decoded instruction
  input wire logic [15:0] acc,              // accumulator
  input wire logic instr_ready,             // unit idle
  input wire branch2_pkg::bus_req_t bus,    // memory request
  input wire logic bus_ack,                 // access done
  input wire logic done,                    // last cycle
  input wire logic [7:0] flags,             // condition codes
  input wire logic reg_we,                  // write-back strobe
  input wire logic [15:0] reg_wdata         // write-back value
);
  logic take;
  assign take = instr_valid && instr_ready;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  accept_busy_a: assert property (take |=> !instr_ready)
    else $error("unit still ready after accept");
  cmpa_taken_a: assert property (take && instr.op == OP_CMP_BYTE_A &&
    acc[7:0] != instr.imm[7:0] |=> !done[*5] ##1 done)
    else $error("taken accumulator compare not 5 cycles");
  cmpa_fall_a: assert property (take && instr.op == OP_CMP_BYTE_A &&
    acc[7:0] == instr.imm[7:0] |=> !done[*4] ##1 done)
    else $error("untaken accumulator compare not 4 cycles");
  cmpb_reg_a: assert property (take && instr.op == OP_CMP_BYTE_REG &&
    instr.opnd[7:0] != instr.imm[7:0] |-> ##14 done)
    else $error("taken byte register compare not 13 cycles");
  cmpw_reg_a: assert property (take && instr.op == OP_CMP_WORD_REG &&
    instr.opnd == instr.imm |=> !done[*7] ##1 done)
    else $error("untaken word register compare not 7 cycles");
  dec_wb_a: assert property (take && instr.op == OP_DEC_WORD_REG |=>
    reg_we && reg_wdata == $past(instr.opnd) - 16'h0001)
    else $error("word decrement write-back wrong");
  dec_fall_a: assert property (take && instr.op == OP_DEC_WORD_REG &&
    instr.opnd == 16'h0001 |=> !done[*6] ##1 done)
    else $error("untaken register decrement not 6 cycles");
  carry_kept_a: assert property (take && (instr.op == OP_DEC_BYTE_REG ||
    instr.op == OP_DEC_WORD_REG) |=> $stable(flags[FLAG_C])[*7])
    else $error("decrement changed carry");
  ret_flags_a: assert property (take && (instr.op == OP_RET_WORD ||
    instr.op == OP_RET_LONG) |=> $stable(flags)[*4])
    else $error("return changed flags");
  bus_hold_a: assert property (bus.req && !bus_ack |=> bus.req &&
    $stable(bus.addr) && $stable(bus.we) && $stable(bus.wdata))
    else $error("bus request changed before ack");
  rmw_lock_a: assert property (bus.req && bus.lock && !bus.we &&
    bus_ack |=> ##[0:20] bus.req && bus.we && bus.lock)
    else $error("locked read not followed by locked write");
  cmp_seen_c: cover property (take && instr.op == OP_CMP_BYTE_REG);
  wb_seen_c: cover property (reg_we);
  lock_seen_c: cover property (bus.req && bus.we && bus.lock && bus_ack);
endmodule
bind cpu_branch_group_two_exec branch2_exec_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
  .instr(instr), .acc(acc), .instr_ready(instr_ready), .bus(bus),
  .bus_ack(bus_ack), .done(done), .flags(flags), .reg_we(reg_we),
  .reg_wdata(reg_wdata));
`default_nettype wire

// file: verification/bus_mem_model.sv
// stack and data memory answering the unit's bus requests
// assumes requests stay steady until acknowledged
`timescale 1ns/100ps
`default_nettype none
module bus_mem_model
  import branch2_pkg::*;
#(
  parameter logic [15:0] FILL = 16'h1a6b
) (
  input wire logic sys_clk,                 // core clock
  input wire logic rst,                     // sync reset
  input wire branch2_pkg::bus_req_t bus,    // request from the unit
  input wire logic slow,                    // add two wait cycles
  output logic bus_ack,                     // access completes
  output logic [15:0] bus_rdata             // read data on ack
);
  logic [15:0] mem [256];
  logic [15:0] last;
  logic [1:0] wait_cnt;
  initial for (int i = 0; i < 256; i++) mem[i] = FILL;
  assign bus_ack = bus.req && (!slow || wait_cnt == 2'h2);
  // outside an ack the data lines must not pass for the old word
  assign bus_rdata = bus_ack ? mem[bus.addr[7:0]] : ~last;
  always @(posedge sys_clk) begin
    if (rst) begin
      wait_cnt <= 2'h0;
      last <= 16'h0000;
    end else if (bus_ack) begin
      wait_cnt <= 2'h0;
      last <= bus_rdata;
      if (bus.we) mem[bus.addr[7:0]] <= bus.wdata;
    end else if (bus.req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_cpu_branch_group_two_exec.sv
// self-checking bench for the branch group two execution unit
// assumes the memory model holds FILL everywhere at start
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_branch_group_two_exec;
  import branch2_pkg::*;
  localparam logic [15:0] FILL = 16'h1a6b;
  localparam logic [15:0] NPC = 16'h2000;
  typedef struct {
    logic [15:0] pc;
    logic [7:0] flags;
    int cyc;
    logic [1:0] wk;
    logic [15:0] wv;
  } note_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic slow = 1'b0;
  instr_t instr = '0;
  logic [15:0] next_pc = 16'h0000;
  logic [15:0] acc = 16'h0000;
  bus_req_t bus;
  logic bus_ack, instr_ready, done, reg_we;
  logic [15:0] bus_rdata, pc, fp, reg_wdata, wd_seen;
  logic [7:0] pc_bank, flags, ef;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 32'h5b84b7d9;
  note_t notes[$];
  always #25 sys_clk = ~sys_clk;
  cpu_branch_group_two_exec u_dut (.sys_clk(sys_clk), .rst(rst),
    .instr_valid(instr_valid), .instr(instr), .next_pc(next_pc),
    .acc(acc), .instr_ready(instr_ready), .bus(bus), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .done(done), .pc(pc), .pc_bank(pc_bank),
    .flags(flags), .sp(), .fp(fp), .reg_we(reg_we),
    .reg_wdata(reg_wdata));
  bus_mem_model #(.FILL(FILL)) u_mem (.sys_clk(sys_clk), .rst(rst),
    .bus(bus), .slow(slow), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  task automatic chk16(input string what, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [3:0] nzvc(input logic [15:0] a, b,
                                      input logic w);
    logic [16:0] r;
    if (w) begin
      r = {1'b0, a} - {1'b0, b};
      return {r[15], r[15:0] == 16'h0, (a[15] ^ b[15]) & (r[15] ^ a[15]),
              r[16]};
    end
    r = {9'h0, a[7:0]} - {9'h0, b[7:0]};
    return {r[7], r[7:0] == 8'h0, (a[7] ^ b[7]) & (r[7] ^ a[7]), r[8]};
  endfunction
  function automatic logic [15:0] tgt(input logic tk, input logic [7:0] d);
    return tk ? NPC + {{8{d[7]}}, d} : NPC;
  endfunction
  // one instruction: note the expectation, offer it, wait for its result
  task automatic run(input op_t op, input logic [15:0] a, im, o,
                     input logic [7:0] d, input logic [15:0] epc,
                     input int cy, input logic [1:0] wk,
                     input logic [15:0] wv);
    note_t n;
    int t;
    n = '{epc, ef, cy, wk, wv};
    @(posedge sys_clk);
    // memory forms always use a plain address, never post-increment
    instr <= '{op, im, d, o, 16'h0040, 5'h03, 24'h123456};
    acc <= a;
    next_pc <= NPC;
    instr_valid <= 1'b1;
    notes.push_back(n);
    for (t = 0; t < 50 && instr_ready !== 1'b1; t++) @(posedge sys_clk);
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    for (t = 0; t < 300 && notes.size() > 0; t++) @(posedge sys_clk);
    if (notes.size() > 0) begin
      n_fail++;
      $display("wrong value done expected 1 seen 0");
      notes.delete();
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= (instr_valid && instr_ready) ? 1 : cyc + 1;
    if (instr_valid && instr_ready) wd_seen <= 16'hxxxx;
    else if (reg_we === 1'b1) wd_seen <= reg_wdata;
  end
  initial begin : mon
    note_t n;
    int k;
    forever begin
      @(posedge sys_clk);
      if (done === 1'b1 && notes.size() > 0) begin
        k = cyc;
        #1;
        n = notes[0];
        chk16("pc", n.pc, pc);
        chk8("flags", n.flags, flags);
        if (n.cyc > 0) chk16("cycles", 16'(n.cyc), 16'(k));
        if (n.wk == 2'h2) chk16("write-back", n.wv, wd_seen);
        if (n.wk == 2'h1) chk8("write-back", n.wv[7:0], wd_seen[7:0]);
        void'(notes.pop_front());
      end
    end
  end
  initial begin : watchdog
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin : main
    logic [4:0] tkl [4];
    logic [4:0] ntl [4];
    logic [15:0] a, im, o;
    logic [7:0] d;
    logic [3:0] f;
    int i;
    tkl = '{CYC_CMP_A_TK, CYC_CMP_A_TK, CYC_CMPB_R_TK, CYC_CMPW_R_TK};
    ntl = '{CYC_CMP_A_NT, CYC_CMP_A_NT, CYC_CMPB_R_NT, CYC_CMPW_R_NT};
    ef = RESET_FLAGS;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // equal, equal low byte only, then random; last leaves carry set
    for (i = 0; i < 16; i++) begin
      a = (i == 15) ? 16'h0000 : 16'($random(seed));
      im = (i < 4) ? a : (i < 8) ? {~a[15:8], a[7:0]} : 16'($random(seed));
      if (i == 15) im = 16'h0001;
      d = 8'($random(seed));
      f = nzvc(a, im, i[0]);
      ef = {ef[7:4], f};
      run(op_t'(4'(i % 4)), a, im, a, d, tgt(!f[2], d),
          1 + int'(f[2] ? ntl[i % 4] : tkl[i % 4]), 2'h0, 16'h0);
    end
    $display("compare test done");
    for (i = 0; i < 8; i++) begin
      o = (i < 2) ? 16'h0001 : (i < 4) ? 16'h0000 : (i < 6) ? 16'h0100 :
          16'($random(seed));
      d = 8'($random(seed));
      f = nzvc(o, 16'h0001, i[0]);
      ef = {ef[7:4], f[3:1], ef[0]};
      run(i[0] ? OP_DEC_WORD_REG : OP_DEC_BYTE_REG, a, 16'h0, o, d,
          tgt(!f[2], d), 1 + int'(f[2] ? CYC_DEC_R_NT : CYC_DEC_R_TK),
          i[0] ? 2'h2 : 2'h1, o - 16'h0001);
    end
    $display("decrement test done");
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      f = nzvc(FILL - 16'(i), FILL + 16'(i), 1'b1);
      ef = {ef[7:4], f};
      run(OP_CMP_WORD_MEM, a, FILL + 16'(i), o, 8'hf0,
          tgt(!f[2], 8'hf0), 5 + 2 * i +
          int'(f[2] ? CYC_CMP_M_NT : CYC_CMP_M_TK), 2'h0, 16'h0);
      f = nzvc(FILL - 16'(i), 16'h0001, 1'b1);
      ef = {ef[7:4], f[3:1], ef[0]};
      run(OP_DEC_WORD_MEM, a, 16'h0, o, 8'h7f, tgt(1'b1, 8'h7f),
          6 + 4 * i + int'(CYC_DEC_M_TK), 2'h0, 16'h0);
      chk16("memory word", FILL - 16'(i + 1), u_mem.mem[8'h40]);
    end
    $display("memory test done");
    // memory stays slow from here: three cycles per stack access
    run(OP_RET_WORD, a, 16'h0, o, 8'h0, FILL,
        4 + int'(CYC_RET_WORD), 2'h0, 16'h0);
    run(OP_RET_LONG, a, 16'h0, o, 8'h0, FILL,
        7 + int'(CYC_RET_LONG), 2'h0, 16'h0);
    chk8("bank", FILL[7:0], pc_bank);
    ef = FILL[7:0];
    run(OP_TRAP_EXIT, a, 16'h0, o, 8'h0, FILL,
        19 + int'(CYC_TRAP_EXIT), 2'h0, 16'h0);
    $display("return test done");
    run(OP_FRAME_SETUP, a, 16'h0004, o, 8'h0, NPC,
        4 + int'(CYC_FRAME), 2'h0, 16'h0);
    run(OP_FRAME_DROP, a, 16'h0, o, 8'h0, NPC,
        4 + int'(CYC_FRAME_DROP), 2'h0, 16'h0);
    chk16("frame pointer", RESET_SP, fp);
    ef[FLAG_S] = 1'b1;
    ef[FLAG_I] = 1'b0;
    run(OP_TRAP_FAR, a, 16'h0, o, 8'h0, 16'h3456,
        16 + int'(CYC_TRAP), 2'h0, 16'h0);
    chk8("bank", 8'h12, pc_bank);
    $display("frame and trap test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
